// ==== verilog/pam_pkg.sv ====
// Package for the Port A alternate-function mux: codes, widths, carriers
package pam_pkg;
   localparam int pam_pins = 6;
   localparam logic [1:0] pam_code_a = 2'h0;
   localparam logic [1:0] pam_code_b = 2'h1;
   localparam logic [1:0] pam_code_c = 2'h2;
   localparam logic [1:0] pam_code_d = 2'h3;
   localparam logic [5:0] pam_analog_capable = 6'h3a;

   // Pad-facing routing decision of one pin
   typedef enum {pam_gpio, pam_drive, pam_sense, pam_analog, pam_reserved} pam_use_t;

   // Peripheral outputs that may drive pads
   typedef struct packed {
      logic timer_zero_out;
      logic timer_one_out;
      logic uart_drive_enable;
      logic uart_transmit_line;
      logic comparator_out;
   } pam_periph_out_t;

   // Inputs fed from pads to peripherals
   typedef struct packed {
      logic timer_zero_in;
      logic timer_one_in;
      logic ext_clock_in;
      logic uart_clear_to_send;
      logic uart_receive_line;
      logic ext_reset_in;
   } pam_periph_in_t;

   // Per-pin pad controls
   typedef struct packed {
      logic [5:0] out;
      logic [5:0] oe;
      logic [5:0] af_active;
      logic [5:0] analog;
   } pam_pad_t;
endpackage

// ==== verilog/pam_pin_decode.sv ====
// Per-pin decode of the two-bit function code to a routing class
`timescale 1ns/1ns
module pam_pin_decode
   import pam_pkg::*;
#(
   parameter int pin = 0
) (
   // Selection
   input wire logic enable,
   input wire logic [1:0] code,
   // Result
   output pam_pkg::pam_use_t use_kind
);
   always_comb begin
      use_kind = pam_reserved;
      if (!enable) begin
         use_kind = pam_gpio;
      end else begin
         unique case (pin)
            0: use_kind = (code == pam_code_a) ? pam_sense :
                          (code == pam_code_d) ? pam_drive : pam_reserved;
            1: use_kind = (code == pam_code_a) ? pam_drive : (code == pam_code_c) ? pam_sense :
                          (code == pam_code_d) ? pam_analog : pam_reserved;
            2: use_kind = (code == pam_code_b) ? pam_sense :
                          (code == pam_code_d) ? pam_reserved : pam_drive;
            3: use_kind = (code == pam_code_a || code == pam_code_c) ? pam_sense :
                          (code == pam_code_b) ? pam_drive : pam_analog;
            4: use_kind = (code == pam_code_a) ? pam_sense :
                          (code == pam_code_d) ? pam_analog : pam_reserved;
            5: use_kind = (code == pam_code_d) ? pam_analog :
                          (code == pam_code_c) ? pam_reserved : pam_drive;
            default: use_kind = pam_reserved;
         endcase
      end
   end
endmodule

// ==== verilog/pam_port_a_mux.sv ====
// Port A alternate-function mux top: registers pad controls and peripheral inputs
`timescale 1ns/1ns
module pam_port_a_mux
   import pam_pkg::*;
#(
   parameter int pins = pam_pins
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Software selection
   input wire logic [5:0] af_enable,
   input wire logic [5:0] func_select_low,
   input wire logic [5:0] func_select_high,
   // General-purpose I/O path
   input wire logic [5:0] gpio_out,
   input wire logic [5:0] gpio_oe,
   // Pads
   input wire logic [5:0] pad_in,
   output pam_pkg::pam_pad_t pad,
   // Peripherals
   input pam_pkg::pam_periph_out_t periph_out,
   output pam_pkg::pam_periph_in_t periph_in,
   output logic [5:0] reserved_selected
);
   import pam_pkg::*;

   typedef struct packed {
      pam_pad_t pad;
      pam_periph_in_t pin_in;
      logic [5:0] reserved;
   } pam_state_t;

   pam_state_t state;
   pam_state_t next_state;
   pam_use_t use_kind [pins];

   // Function code: func_select_low is the upper bit, func_select_high the lower
   for (genvar i = 0; i < pins; i++) begin : g_dec
      pam_pin_decode #(.pin(i)) u_dec (
         .enable(af_enable[i]),
         .code({func_select_low[i], func_select_high[i]}),
         .use_kind(use_kind[i])
      );
   end

   // Value a pin drives when its code selects an output function
   function automatic logic drive_value(input int p, input logic [1:0] c, input pam_periph_out_t po);
      logic v;
      v = 1'b0;
      unique case (p)
         0: v = ~po.timer_zero_out;
         1: v = po.timer_zero_out;
         2: v = (c == pam_code_a) ? po.uart_drive_enable : po.timer_one_out;
         3: v = po.comparator_out;
         5: v = (c == pam_code_a) ? po.uart_transmit_line : ~po.timer_one_out;
         default: v = 1'b0;
      endcase
      return v;
   endfunction

   always_comb begin
      next_state = '0;
      // Idle levels of inputs when not routed
      next_state.pin_in.uart_clear_to_send = 1'b1;
      next_state.pin_in.uart_receive_line = 1'b1;
      next_state.pin_in.ext_reset_in = 1'b1;
      for (int i = 0; i < pins; i++) begin
         next_state.pad.out[i] = gpio_out[i];
         next_state.pad.oe[i] = gpio_oe[i];
         next_state.pad.af_active[i] = (use_kind[i] != pam_gpio);
         unique case (use_kind[i])
            pam_gpio: begin
            end
            pam_drive: begin
               next_state.pad.out[i] = drive_value(i, {func_select_low[i], func_select_high[i]}, periph_out);
               next_state.pad.oe[i] = 1'b1;
            end
            pam_sense: begin
               next_state.pad.oe[i] = 1'b0;
               next_state.pad.out[i] = 1'b0;
            end
            pam_analog: begin
               next_state.pad.oe[i] = 1'b0;
               next_state.pad.out[i] = 1'b0;
               next_state.pad.analog[i] = pam_analog_capable[i];
            end
            pam_reserved: begin
               next_state.pad.oe[i] = 1'b0;
               next_state.pad.out[i] = 1'b0;
               next_state.reserved[i] = 1'b1;
            end
         endcase
      end
      if (use_kind[0] == pam_sense) next_state.pin_in.timer_zero_in = pad_in[0];
      if (use_kind[1] == pam_sense) next_state.pin_in.ext_clock_in = pad_in[1];
      if (use_kind[2] == pam_sense) next_state.pin_in.ext_reset_in = pad_in[2];
      if (use_kind[3] == pam_sense) begin
         if (func_select_low[3]) begin
            next_state.pin_in.timer_one_in = pad_in[3];
         end else begin
            next_state.pin_in.uart_clear_to_send = pad_in[3];
         end
      end
      if (use_kind[4] == pam_sense) next_state.pin_in.uart_receive_line = pad_in[4];
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state <= '0;
         state.pin_in.uart_clear_to_send <= 1'b1;
         state.pin_in.uart_receive_line <= 1'b1;
         state.pin_in.ext_reset_in <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign pad = state.pad;
   assign periph_in = state.pin_in;
   assign reserved_selected = state.reserved;
endmodule

// ==== test/pam_mux_props.sv ====
// Concurrent checks on the Port A mux ports
`timescale 1ns/1ns
module pam_mux_props
   import pam_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Selection and GPIO
   input wire logic [5:0] af_enable,
   input wire logic [5:0] func_select_low,
   input wire logic [5:0] func_select_high,
   input wire logic [5:0] gpio_out,
   input wire logic [5:0] gpio_oe,
   // Pads and peripherals
   input wire logic [5:0] pad_in,
   input pam_pkg::pam_pad_t pad,
   input pam_pkg::pam_periph_out_t periph_out,
   input pam_pkg::pam_periph_in_t periph_in
);
   wire [5:0] s00 = af_enable & ~func_select_low & ~func_select_high;
   wire [5:0] s01 = af_enable & ~func_select_low & func_select_high;
   wire [5:0] s10 = af_enable & func_select_low & ~func_select_high;
   wire [5:0] s11 = af_enable & func_select_low & func_select_high;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   a_gpio_path: assert property (1 |=> (((pad.out ^ $past(gpio_out)) | (pad.oe ^ $past(gpio_oe))) & ~$past(af_enable)) == 6'h0)
      else $error("GPIO path wrong");
   a_pin0_inv: assert property (s11[0] |=> pad.oe[0] && pad.out[0] == !$past(periph_out.timer_zero_out))
      else $error("Pin 0 drive wrong");
   a_pin2_reset: assert property (s01[2] |=> !pad.oe[2] && periph_in.ext_reset_in == $past(pad_in[2]))
      else $error("Pin 2 reset path wrong");
   a_pin3_cmp: assert property (s01[3] |=> pad.oe[3] && pad.out[3] == $past(periph_out.comparator_out))
      else $error("Pin 3 drive wrong");
   a_pin5_tx: assert property (s00[5] |=> pad.oe[5] && pad.out[5] == $past(periph_out.uart_transmit_line))
      else $error("Pin 5 transmit wrong");
   a_pin5_inv: assert property (s01[5] |=> pad.out[5] == !$past(periph_out.timer_one_out))
      else $error("Pin 5 drive wrong");
   a_analog_sel: assert property (1 |=> pad.analog == ($past(s11) & 6'h3a))
      else $error("Analog hand-over wrong");
   a_pin0_in: assert property (s00[0] |=> !pad.oe[0] && periph_in.timer_zero_in == $past(pad_in[0]))
      else $error("Pin 0 input path wrong");
   a_pin1_drive: assert property (s00[1] |=> pad.oe[1] && pad.out[1] == $past(periph_out.timer_zero_out))
      else $error("Pin 1 drive wrong");
   a_pin2_enable: assert property (s00[2] |=> pad.oe[2] && pad.out[2] == $past(periph_out.uart_drive_enable))
      else $error("Pin 2 drive enable wrong");
   a_pin2_timer: assert property (s10[2] |=> pad.oe[2] && pad.out[2] == $past(periph_out.timer_one_out))
      else $error("Pin 2 timer drive wrong");
   a_pin3_timer: assert property (s10[3] |=> !pad.oe[3] && periph_in.timer_one_in == $past(pad_in[3]))
      else $error("Pin 3 timer input wrong");
   a_pin4_rx: assert property (s00[4] |=> !pad.oe[4] && periph_in.uart_receive_line == $past(pad_in[4]))
      else $error("Pin 4 receive path wrong");
   a_pin4_reserved: assert property ((s01[4] || s10[4]) |=> !pad.oe[4] && !pad.analog[4])
      else $error("Pin 4 reserved code drives");
   a_pin1_clock: assert property (s10[1] |=> !pad.oe[1] && periph_in.ext_clock_in == $past(pad_in[1]))
      else $error("Pin 1 clock path wrong");
endmodule
bind pam_port_a_mux pam_mux_props u_props (.clock, .reset, .af_enable, .func_select_low, .func_select_high,
   .gpio_out, .gpio_oe, .pad_in, .pad, .periph_out, .periph_in);

// ==== test/pam_periph_model.sv ====
// Peripherals and pad levels facing the mux
`timescale 1ns/1ns
module pam_periph_model
   import pam_pkg::*;
(
   // Clock
   input wire logic clock,
   // Toward the mux
   output pam_pkg::pam_periph_out_t periph_out,
   output logic [5:0] pad_in
);
   logic [5:0] count = 6'h0;
   // Levels move every cycle so a stale route shows
   always @(posedge clock) count <= #1 count + 6'h5;
   assign periph_out = pam_periph_out_t'(count[4:0] ^ 5'h0a);
   assign pad_in = ~count;
endmodule

// ==== test/test_port_a_alt_function_mux.sv ====
// Bench for the Port A alternate-function mux
`timescale 1ns/1ns
`define CHK(a, b) begin \
   samples_checked++; \
   if ((a) !== (b)) begin \
      failures++; \
      $display("[FAIL] %0t got %h exp %h", $time, a, b); \
   end \
end
module test_port_a_alt_function_mux;
   import pam_pkg::*;
   logic clock = 0, reset = 1;
   logic [5:0] en = 0, low = 0, high = 0, gout = 0, goe = 6'h2d, snap, pad_in, res;
   int failures = 0, samples_checked = 0, cycles = 0;
   pam_pad_t pad;
   pam_periph_out_t pout;
   pam_periph_in_t pin;
   // Enable, low, high, then oe, analog, reserved
   logic [35:0] rows [6] = '{{6'h3f, 6'h00, 6'h00, 6'h26, 6'h00, 6'h00},
      {6'h3f, 6'h00, 6'h3f, 6'h28, 6'h00, 6'h13}, {6'h3f, 6'h3f, 6'h00, 6'h04, 6'h00, 6'h31},
      {6'h3f, 6'h3f, 6'h3f, 6'h01, 6'h3a, 6'h04}, {6'h00, 6'h3f, 6'h3f, 6'h2d, 6'h00, 6'h00},
      {6'h15, 6'h3f, 6'h3f, 6'h29, 6'h10, 6'h04}};
   pam_port_a_mux DUT (.clock(clock), .reset(reset), .af_enable(en), .func_select_low(low),
      .func_select_high(high), .gpio_out(gout), .gpio_oe(goe), .pad_in(pad_in), .pad(pad),
      .periph_out(pout), .periph_in(pin), .reserved_selected(res));
   pam_periph_model partner (.clock(clock), .periph_out(pout), .pad_in(pad_in));
   initial forever #5 clock = ~clock;
   always @(posedge clock) if (++cycles == 300) begin
      failures++;
      close_out();
   end
   task close_out();
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clock);
      #1 reset = 0;
      foreach (rows[i]) begin
         @(posedge clock);
         #1 {en, low, high} = rows[i][35:18];
         gout = 6'(i * 7);
         @(posedge clock);
         #2 `CHK(pad.oe, rows[i][17:12])
         `CHK(pad.analog, rows[i][11:6])
         `CHK(res, rows[i][5:0])
         `CHK(pad.out & ~en, gout & ~en)
         `CHK(pad.af_active, en)
      end
      // Second reset in mid-run, then all pins on code 00
      @(posedge clock);
      #1 reset = 1;
      #1 `CHK({pad, pin, res}, {24'h0, 6'h07, 6'h00})
      @(posedge clock);
      #1 reset = 0;
      {en, low, high} = {6'h3f, 6'h00, 6'h00};
      @(posedge clock);
      snap = pad_in;
      #2 `CHK(pin, {snap[0], 2'h0, snap[3], snap[4], 1'b1})
      // All pins back to GPIO with a different enable pattern
      @(posedge clock);
      #1 en = 6'h00;
      goe = 6'h12;
      gout = 6'h2a;
      @(posedge clock);
      #2 `CHK({pad.oe, pad.out, pad.af_active}, {6'h12, 6'h2a, 6'h00})
      close_out();
   end
endmodule
